//--- sabbe_pkg.sv
// Shared types and constants for the shift/add/bit/branch execution datapath
package sabbe_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int BIDX_W = 3;
	localparam int OFS_W = 9;
	localparam int PC_W = 15;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int MSB_POS = 7;
	localparam int NIB_W = 4;
	localparam logic DEST_W_REG = 1'h0;
	localparam logic DEST_FILE = 1'h1;
	localparam logic [DATA_W-1:0] W_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic FLAG_RST = 1'h0;

	// ----------------------------------------
	// Timing counts, in instruction cycles
	// ----------------------------------------
	localparam int TWO_CYCLE_OP = 2;
	localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

	typedef enum logic [2:0] {
		nop_op,
		arith_shift_right_op,
		add_with_carry_op,
		bit_clear_op,
		skip_if_bit_clear_op,
		skip_if_bit_set_op,
		relative_branch_op
	} sabbe_op_t;

	typedef struct packed {
		sabbe_op_t op;
		logic [FADDR_W-1:0] faddr;
		logic [BIDX_W-1:0] bidx;
		logic dest;
		logic [OFS_W-1:0] offset;
	} sabbe_req_t;

	typedef struct packed {
		logic c;
		logic half_carry_flag;
		logic z;
	} sabbe_flags_t;

	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sabbe_fwr_t;

endpackage : sabbe_pkg

//--- sabbe_exec.sv
// Execution datapath for shift, add-with-carry, bit clear, bit test-skip and relative branch
`timescale 1ns/100ps
`default_nettype none

module sabbe_exec
	import sabbe_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	input wire sabbe_req_t REQ,
	input wire logic [DATA_W-1:0] FILE_RDATA,
	output logic BUSY,
	output logic FLUSH,
	output logic [DATA_W-1:0] W_REG,
	output sabbe_flags_t FLAGS,
	output logic [PC_W-1:0] PC,
	output sabbe_fwr_t FILE_WR
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic bit_of(input logic [DATA_W-1:0] v, input logic [BIDX_W-1:0] idx);
		bit_of = v[idx];
	endfunction : bit_of

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		is_zero = (v == '0);
	endfunction : is_zero

	typedef enum logic {EXEC, NOP_SLOT} sabbe_state_t;

	sabbe_state_t state_ff;
	logic [DATA_W-1:0] w_ff;
	sabbe_flags_t flags_ff;
	logic [PC_W-1:0] pc_ff;
	sabbe_fwr_t fwr_ff;
	logic flush_ff;

	// ----------------------------------------
	// Operand decode
	// ----------------------------------------
	logic take;
	logic [DATA_W-1:0] asr_res;
	logic [DATA_W:0] add_sum;
	logic [NIB_W:0] add_nib;
	logic [DATA_W-1:0] bcf_res;
	logic test_bit;
	logic skip_now;
	logic [PC_W-1:0] bra_target;
	logic [DATA_W-1:0] nxt_w;
	logic [PC_W-1:0] nxt_pc;

	assign take = REQ_VALID && (state_ff == EXEC);
	assign asr_res = {FILE_RDATA[MSB_POS], FILE_RDATA[MSB_POS:1]};
	assign add_sum = {1'h0, w_ff} + {1'h0, FILE_RDATA}
		+ {{DATA_W{1'h0}}, flags_ff.c};
	assign add_nib = {1'h0, w_ff[NIB_W-1:0]} + {1'h0, FILE_RDATA[NIB_W-1:0]}
		+ {{NIB_W{1'h0}}, flags_ff.c};
	assign bcf_res = FILE_RDATA & ~(8'h01 << REQ.bidx);
	assign test_bit = bit_of(FILE_RDATA, REQ.bidx);
	// Skip taken: clear-test on a 0 bit, set-test on a 1 bit
	assign skip_now = ((REQ.op == skip_if_bit_clear_op) && !test_bit)
		|| ((REQ.op == skip_if_bit_set_op) && test_bit);
	// Offset is relative to the already incremented PC
	assign bra_target = pc_ff + PC_STEP
		+ {{(PC_W-OFS_W){REQ.offset[OFS_W-1]}}, REQ.offset};

	always_comb begin
		nxt_w = w_ff;
		if (take && (REQ.dest == DEST_W_REG)) begin
			case (REQ.op)
				arith_shift_right_op: nxt_w = asr_res;
				add_with_carry_op: nxt_w = add_sum[DATA_W-1:0];
				default: nxt_w = w_ff;
			endcase
		end
	end

	always_comb begin
		nxt_pc = pc_ff;
		if (take) begin
			case (REQ.op)
				relative_branch_op: nxt_pc = bra_target;
				// The discarded instruction's address is stepped over here, its slot runs as a NOP
				skip_if_bit_clear_op, skip_if_bit_set_op:
					nxt_pc = skip_now ? pc_ff + PC_STEP + PC_STEP : pc_ff + PC_STEP;
				default: nxt_pc = pc_ff + PC_STEP;
			endcase
		end
	end

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_ff <= EXEC;
		end else begin
			case (state_ff)
				EXEC: begin
					if (take && (skip_now || REQ.op == relative_branch_op)) begin
						state_ff <= NOP_SLOT;
					end
				end
				NOP_SLOT: state_ff <= EXEC;
				default: state_ff <= EXEC;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			flush_ff <= 1'h0;
		end else begin
			flush_ff <= take && (skip_now || REQ.op == relative_branch_op);
		end
	end

	// ----------------------------------------
	// Working register and program counter
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			w_ff <= W_RST;
		end else begin
			w_ff <= nxt_w;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pc_ff <= PC_RST;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			flags_ff <= '{c: FLAG_RST, half_carry_flag: FLAG_RST, z: FLAG_RST};
		end else if (take) begin
			case (REQ.op)
				arith_shift_right_op: begin
					flags_ff.c <= FILE_RDATA[0];
					flags_ff.z <= is_zero(asr_res);
				end
				add_with_carry_op: begin
					flags_ff.c <= add_sum[DATA_W];
					flags_ff.half_carry_flag <= add_nib[NIB_W];
					flags_ff.z <= is_zero(add_sum[DATA_W-1:0]);
				end
				default: flags_ff <= flags_ff;
			endcase
		end
	end

	// ----------------------------------------
	// File register write-back
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fwr_ff <= '0;
		end else begin
			fwr_ff.we <= 1'h0;
			fwr_ff.addr <= REQ.faddr;
			fwr_ff.wdata <= fwr_ff.wdata;
			if (take) begin
				case (REQ.op)
					arith_shift_right_op: begin
						fwr_ff.we <= (REQ.dest == DEST_FILE);
						fwr_ff.wdata <= asr_res;
					end
					add_with_carry_op: begin
						fwr_ff.we <= (REQ.dest == DEST_FILE);
						fwr_ff.wdata <= add_sum[DATA_W-1:0];
					end
					bit_clear_op: begin
						fwr_ff.we <= 1'h1;
						fwr_ff.wdata <= bcf_res;
					end
					default: fwr_ff.we <= 1'h0;
				endcase
			end
		end
	end

	assign BUSY = (state_ff == NOP_SLOT);
	assign FLUSH = flush_ff;
	assign W_REG = w_ff;
	assign FLAGS = flags_ff;
	assign PC = pc_ff;
	assign FILE_WR = fwr_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence take_seq(sabbe_op_t o);
		take && REQ.op == o;
	endsequence

	sequence nop_slot_seq;
		BUSY ##1 !BUSY;
	endsequence

	asr_shift_a: assert property (
		take_seq(arith_shift_right_op) and REQ.dest == DEST_W_REG
		|=> W_REG == {$past(FILE_RDATA[7]), $past(FILE_RDATA[7:1])}
		&& FLAGS.c == $past(FILE_RDATA[0]))
		else $error("shift result or carry wrong");
	asr_dest_file_a: assert property (
		take_seq(arith_shift_right_op) and REQ.dest == DEST_FILE
		|=> FILE_WR.we && FILE_WR.addr == $past(REQ.faddr)
		&& FILE_WR.wdata == {$past(FILE_RDATA[7]), $past(FILE_RDATA[7:1])}
		&& $stable(W_REG) && $stable(FLAGS.half_carry_flag))
		else $error("shift to file misrouted");
	adc_sum_a: assert property (
		take_seq(add_with_carry_op) and REQ.dest == DEST_W_REG
		|=> {FLAGS.c, W_REG} == ({1'h0, $past(W_REG)} + {1'h0, $past(FILE_RDATA)}
		+ {8'h00, $past(FLAGS.c)})
		&& FLAGS.half_carry_flag == (({1'h0, $past(W_REG[3:0])}
		+ {1'h0, $past(FILE_RDATA[3:0])} + {4'h0, $past(FLAGS.c)}) > 5'h0F))
		else $error("add with carry wrong");
	adc_dest_file_a: assert property (
		take_seq(add_with_carry_op) and REQ.dest == DEST_FILE
		|=> FILE_WR.we && FILE_WR.addr == $past(REQ.faddr) && $stable(W_REG)
		&& {FLAGS.c, FILE_WR.wdata} == ({1'h0, $past(W_REG)} + {1'h0, $past(FILE_RDATA)}
		+ {8'h00, $past(FLAGS.c)}))
		else $error("add with carry to file wrong");
	bcf_clear_a: assert property (
		take_seq(bit_clear_op)
		|=> FILE_WR.we && FILE_WR.addr == $past(REQ.faddr)
		&& FILE_WR.wdata == ($past(FILE_RDATA) & ~(8'h01 << $past(REQ.bidx)))
		&& $stable(FLAGS) && $stable(W_REG))
		else $error("bit clear wrong");
	skip_clear_a: assert property (
		take_seq(skip_if_bit_clear_op) and !test_bit
		|=> FLUSH and nop_slot_seq)
		else $error("clear-test skip not two cycles");
	skip_set_a: assert property (
		take_seq(skip_if_bit_set_op)
		|=> BUSY == $past(test_bit) && FLUSH == $past(test_bit) && $stable(FLAGS))
		else $error("set-test skip wrong");
	branch_pc_a: assert property (
		take_seq(relative_branch_op)
		|=> PC == $past(PC) + PC_STEP + PC_W'($signed($past(REQ.offset)))
		&& $stable(FLAGS) ##0 nop_slot_seq)
		else $error("branch target or timing wrong");
	zero_flag_a: assert property (
		take_seq(arith_shift_right_op) or take_seq(add_with_carry_op)
		|=> FLAGS.z == ((($past(REQ.dest) == DEST_FILE) ? FILE_WR.wdata : W_REG) == 8'h00))
		else $error("zero flag wrong");

endmodule : sabbe_exec

`default_nettype wire

//--- tb.sv
// Self-checking testbench for the execution datapath
`timescale 1ns/100ps
`default_nettype none

module tb
	import sabbe_pkg::*;
;
	logic CLK = 1'h0;
	logic RST_N = 1'h0;
	logic REQ_VALID = 1'h0;
	sabbe_req_t REQ = '0;
	logic [DATA_W-1:0] FILE_RDATA = 8'h00;
	logic BUSY, FLUSH;
	logic [DATA_W-1:0] W_REG;
	sabbe_flags_t FLAGS;
	logic [PC_W-1:0] PC;
	sabbe_fwr_t FILE_WR;
	int failures = 0;
	int tests_run = 0;
	logic [7:0] w_e = 8'h00;
	logic [2:0] fl_e = 3'h0;
	logic [PC_W-1:0] pc_e = 15'h0000;

	sabbe_exec i_dut (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.FILE_RDATA(FILE_RDATA), .BUSY(BUSY), .FLUSH(FLUSH), .W_REG(W_REG), .FLAGS(FLAGS),
		.PC(PC), .FILE_WR(FILE_WR));

	always #5 CLK = ~CLK;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic st();
		chk("W_REG", {8'h00, w_e}, {8'h00, W_REG});
		chk("FLAGS", {13'h0000, fl_e}, {13'h0000, FLAGS});
		chk("PC", {1'h0, pc_e}, {1'h0, PC});
	endtask : st

	// Called at a falling edge; returns at the falling edge after the taking edge
	task automatic op(input sabbe_op_t o, input logic [6:0] fa, input logic [2:0] b,
		input logic d, input logic [8:0] k, input logic [7:0] fd);
		REQ = '{op: o, faddr: fa, bidx: b, dest: d, offset: k};
		FILE_RDATA = fd;
		REQ_VALID = 1'h1;
		@(posedge CLK);
		@(negedge CLK);
		REQ_VALID = 1'h0;
	endtask : op

	task automatic fwr(input logic we, input logic [6:0] a, input logic [7:0] wd);
		chk("FILE_WR.we", {15'h0000, we}, {15'h0000, FILE_WR.we});
		if (we) begin
			chk("FILE_WR.addr", {9'h000, a}, {9'h000, FILE_WR.addr});
			chk("FILE_WR.wdata", {8'h00, wd}, {8'h00, FILE_WR.wdata});
		end
	endtask : fwr

	// Checks the discarded slot; the add offered inside it must be ignored
	task automatic two_cycle();
		chk("BUSY", 16'h0001, {15'h0000, BUSY});
		chk("FLUSH", 16'h0001, {15'h0000, FLUSH});
		st();
		op(add_with_carry_op, 7'h01, 3'h0, 1'h1, 9'h000, 8'h55);
		chk("BUSY", 16'h0000, {15'h0000, BUSY});
		chk("FLUSH", 16'h0000, {15'h0000, FLUSH});
		fwr(1'h0, 7'h00, 8'h00);
		st();
	endtask : two_cycle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_shift();
		op(arith_shift_right_op, 7'h05, 3'h0, 1'h1, 9'h000, 8'h81);
		fl_e = 3'h4;
		pc_e++;
		fwr(1'h1, 7'h05, 8'hC0);
		st();
		op(arith_shift_right_op, 7'h06, 3'h0, 1'h0, 9'h000, 8'h01);
		fl_e = 3'h5;
		pc_e++;
		fwr(1'h0, 7'h00, 8'h00);
		st();
	endtask : t_shift

	task automatic t_add();
		op(add_with_carry_op, 7'h10, 3'h0, 1'h0, 9'h000, 8'h0F);
		w_e = 8'h10;
		fl_e = 3'h2;
		pc_e++;
		st();
		op(add_with_carry_op, 7'h7F, 3'h0, 1'h1, 9'h000, 8'hF0);
		fl_e = 3'h5;
		pc_e++;
		fwr(1'h1, 7'h7F, 8'h00);
		st();
	endtask : t_add

	task automatic t_clear();
		for (int b = 0; b < 8; b++) begin
			op(bit_clear_op, 7'(b), 3'(b), 1'h0, 9'h000, 8'hFF);
			pc_e++;
			fwr(1'h1, 7'(b), 8'hFF ^ (8'h01 << b));
			st();
		end
	endtask : t_clear

	task automatic t_skip();
		op(skip_if_bit_clear_op, 7'h20, 3'h3, 1'h0, 9'h000, 8'h08);
		pc_e++;
		chk("FLUSH", 16'h0000, {15'h0000, FLUSH});
		st();
		op(skip_if_bit_clear_op, 7'h20, 3'h3, 1'h0, 9'h000, 8'hF7);
		pc_e += 15'h0002;
		two_cycle();
		op(skip_if_bit_set_op, 7'h21, 3'h7, 1'h0, 9'h000, 8'h7F);
		pc_e++;
		chk("FLUSH", 16'h0000, {15'h0000, FLUSH});
		st();
		op(skip_if_bit_set_op, 7'h21, 3'h7, 1'h0, 9'h000, 8'h80);
		pc_e += 15'h0002;
		two_cycle();
	endtask : t_skip

	task automatic t_branch();
		logic [8:0] ks [3] = '{9'h1FF, 9'h0FF, 9'h100};
		foreach (ks[i]) begin
			op(relative_branch_op, 7'h00, 3'h0, 1'h0, ks[i], 8'h00);
			pc_e = pc_e + 15'h0001 + {{6{ks[i][8]}}, ks[i]};
			two_cycle();
		end
	endtask : t_branch

	// Reset inside a discarded slot must clear it; an idle op straight after release steps PC
	task automatic t_reset();
		op(skip_if_bit_set_op, 7'h22, 3'h0, 1'h0, 9'h000, 8'h01);
		RST_N = 1'h0;
		@(negedge CLK);
		RST_N = 1'h1;
		w_e = 8'h00;
		fl_e = 3'h0;
		pc_e = 15'h0000;
		chk("BUSY", 16'h0000, {15'h0000, BUSY});
		chk("FLUSH", 16'h0000, {15'h0000, FLUSH});
		fwr(1'h0, 7'h00, 8'h00);
		st();
		op(nop_op, 7'h00, 3'h0, 1'h0, 9'h000, 8'h00);
		pc_e++;
		fwr(1'h0, 7'h00, 8'h00);
		st();
	endtask : t_reset

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge CLK);
		RST_N = 1'h1;
		st();
		t_shift();
		t_add();
		t_clear();
		t_skip();
		t_branch();
		t_reset();
		test_done();
	end

	// The run needs about 47 cycles; allow a wide margin
	initial begin
		#20000;
		failures++;
		test_done();
	end
endmodule : tb

`default_nettype wire
